// file: core/snb_bus_front.sv
// pin-level serial bus front end of the serial nand device
// Overview of operation
// - write-protect low with lock write disable set blocks protect bit updates
// - deselected: write-protect pin is only an input, never driven
// - pause function off by default; hold pin ignored unless enabled
// - paused: serial output high impedance, clock and serial input ignored
// - pause starts at hold fall if clock low, else next clock fall
// - pause ends at hold rise if clock low, else after next clock fall
// - sample inputs on rising clock, change outputs after falling clock
// - deselected: all four lines are inputs, none driven
// - column address 12 bits; only 0 to 2175 valid
// - row address bit 6 selects the plane
// - clock mode 0 or 3; idle level tells which
// - standard protocol: one line in on serial input, one out
// - extended: command and address on serial input, data on two or four
// - chip select high deselects and floats serial output
module snb_bus_front
  import snb_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic [3:0]           io_in,
  output logic      [3:0]           io_out,
  output logic      [3:0]           io_oe_n,
  input  wire logic                 hold_en,
  input  wire logic [1:0]           rx_lanes,
  input  wire logic                 tx_active,
  input  wire logic [1:0]           tx_lanes,
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic [7:0]                rx_data,
  output logic                      rx_first,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic                      rx_overrun,
  output logic                      selected,
  output logic                      held,
  output logic                      mode3,
  input  wire logic                 lock_reg_write_disable,
  input  wire logic                 bp_wr,
  input  wire logic [3:0]           bp_wr_data,
  input  wire logic                 tb_wr_data,
  output logic [3:0]                block_protect_bits,
  output logic                      top_bottom_select,
  output logic                      bp_wr_refused,
  output logic                      wp_n_level,
  input  wire logic [11:0]          col_addr,
  input  wire logic [`SNB_ROW_W-1:0] row_addr,
  output logic                      col_in_bounds,
  output logic                      plane_select
);
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic       sck_p_q;
  logic       sel_p_q;
  logic       hold_p_q;
  snb_hold_e  hs_q;
  logic       sck_s;
  logic       sel;
  logic       hold_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       sel_rise;
  logic       quad_tx;
  logic       hold_on;
  logic       paused;
  logic       live;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic       rx_first_q;
  logic       push_q;
  snb_word_s  word_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] io_out_q;
  logic [3:0] oe_n_q;
  logic [3:0] bp_q;
  logic       tb_q;
  logic       refused_q;
  logic       wp_n_q;
  logic       mode3_q;
  logic       overrun_q;
  logic       col_ok_q;
  logic       plane_q;
  logic [7:0] tx_byte;
  logic       tx_step;

  snb_stream_if #(.W(9)) rx_in_if ();
  snb_stream_if #(.W(9)) rx_out_if ();

  function automatic logic [3:0] lane_bits(input logic [1:0] ln);
    case (ln)
      `SNB_LN_X2: lane_bits = 4'h2;
      `SNB_LN_X4: lane_bits = 4'h4;
      default:    lane_bits = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic [3:0] io,
                                          input logic [1:0] ln);
    case (ln)
      `SNB_LN_X2: shift_in = {sh[5:0], io[1:0]};
      `SNB_LN_X4: shift_in = {sh[3:0], io};
      default:    shift_in = {sh[6:0], io[0]};
    endcase
  endfunction

  // unused lanes idle high; their enables are off anyway
  function automatic logic [3:0] lanes_out(input logic [7:0] b,
                                           input logic [1:0] ln);
    case (ln)
      `SNB_LN_X2: lanes_out = {2'h3, b[7], b[6]};
      `SNB_LN_X4: lanes_out = b[7:4];
      default:    lanes_out = {2'h3, b[7], 1'b1};
    endcase
  endfunction

  // every pin, the link clock included, passes two flops first
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s1_q <= `SNB_SYNC_RST;
      s2_q <= `SNB_SYNC_RST;
    end
    else
    begin
      s1_q <= {io_in, cs_n, sck};
      s2_q <= s1_q;
    end
  end

  assign sck_s    = s2_q[0];
  assign sel      = ~s2_q[1];
  assign hold_s   = s2_q[5];
  assign sck_rise = sck_s & ~sck_p_q;
  assign sck_fall = ~sck_s & sck_p_q;
  assign sel_rise = sel & ~sel_p_q;
  assign quad_tx  = sel & tx_active & (tx_lanes == `SNB_LN_X4);
  // line 3 carries data in quad reads, so hold cannot act then
  assign hold_on  = hold_en & ~quad_tx;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sck_p_q  <= 1'b0;
      sel_p_q  <= 1'b0;
      hold_p_q <= 1'b1;
    end
    else
    begin
      sck_p_q  <= sck_s;
      sel_p_q  <= sel;
      hold_p_q <= hold_s;
    end
  end

  // clock level at select tells the mode
  always_ff @(posedge mclk)
  begin
    if (srst)
      mode3_q <= 1'b0;
    else if (sel_rise)
      mode3_q <= sck_s;
  end

  always_ff @(posedge mclk)
  begin
    if (srst || !sel || !hold_on)
      hs_q <= HS_RUN;
    else
    begin
      case (hs_q)
        HS_RUN:
          if (!hold_s && hold_p_q)
            hs_q <= sck_s ? HS_ENTER : HS_HELD;
        HS_ENTER:
          if (hold_s)
            hs_q <= HS_RUN;
          else if (sck_fall)
            hs_q <= HS_HELD;
        HS_HELD:
          if (hold_s && !hold_p_q)
            hs_q <= sck_s ? HS_EXIT : HS_RUN;
        HS_EXIT:
          if (!hold_s)
            hs_q <= HS_HELD;
          else if (sck_fall)
            hs_q <= HS_RUN;
        default:
          hs_q <= HS_RUN;
      endcase
    end
  end

  // the clock fall that enters or leaves a pause is swallowed
  assign paused = (hs_q == HS_HELD) || (hs_q == HS_EXIT) ||
                  ((hs_q == HS_ENTER) && sck_fall);
  assign live   = sel & ~paused;

  always_ff @(posedge mclk)
  begin
    if (srst || !sel)
    begin
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 4'h0;
      rx_first_q <= 1'b1;
      push_q     <= 1'b0;
      word_q     <= '0;
    end
    else
    begin
      push_q <= 1'b0;
      if (live && sck_rise && !tx_active)
      begin
        rx_sh_q <= shift_in(rx_sh_q, s2_q[5:2], rx_lanes);
        if (rx_cnt_q + lane_bits(rx_lanes) >= 4'h8)
        begin
          rx_cnt_q   <= 4'h0;
          rx_first_q <= 1'b0;
          push_q     <= 1'b1;
          word_q     <= '{first: rx_first_q,
                          data: shift_in(rx_sh_q, s2_q[5:2], rx_lanes)};
        end
        else
          rx_cnt_q <= rx_cnt_q + lane_bits(rx_lanes);
      end
    end
  end

  // the host cannot be stalled; a word met by a full buffer is dropped
  always_ff @(posedge mclk)
  begin
    if (srst)
      overrun_q <= 1'b0;
    else if (push_q && !rx_in_if.ready)
      overrun_q <= 1'b1;
    else if (sel_rise)
      overrun_q <= 1'b0;
  end

  assign rx_in_if.valid = push_q;
  assign rx_in_if.data  = word_q;

  snb_fifo2 #(.W(9), .DEPTH(2)) u_rx_buf
  (
    .mclk (mclk),
    .srst (srst),
    .wr   (rx_in_if.snk),
    .rd   (rx_out_if.src)
  );

  assign rx_valid        = rx_out_if.valid;
  assign rx_first        = rx_out_if.data[8];
  assign rx_data         = rx_out_if.data[7:0];
  assign rx_out_if.ready = rx_ready;

  assign tx_step  = live & sck_fall & tx_active;
  assign tx_ready = tx_step & (tx_cnt_q == 4'h0);
  assign tx_byte  = tx_valid ? tx_data : `SNB_TX_FILL;

  always_ff @(posedge mclk)
  begin
    if (srst || !sel || !tx_active)
    begin
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 4'h0;
      io_out_q <= 4'hF;
    end
    else if (tx_step)
    begin
      if (tx_cnt_q == 4'h0)
      begin
        io_out_q <= lanes_out(tx_byte, tx_lanes);
        tx_sh_q  <= tx_byte << lane_bits(tx_lanes);
        tx_cnt_q <= 4'h8 - lane_bits(tx_lanes);
      end
      else
      begin
        io_out_q <= lanes_out(tx_sh_q, tx_lanes);
        tx_sh_q  <= tx_sh_q << lane_bits(tx_lanes);
        tx_cnt_q <= tx_cnt_q - lane_bits(tx_lanes);
      end
    end
  end

  // enables low only while selected, reading and not paused
  always_ff @(posedge mclk)
  begin
    if (srst)
      oe_n_q <= 4'hF;
    else
    begin
      oe_n_q[1] <= ~(live & tx_active);
      oe_n_q[0] <= ~(live & tx_active &
                     (tx_lanes != `SNB_LN_X1));
      oe_n_q[2] <= ~(live & quad_tx);
      oe_n_q[3] <= ~(live & quad_tx);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      wp_n_q <= 1'b1;
    else if (!quad_tx)
      wp_n_q <= s2_q[4];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bp_q      <= `SNB_BP_RST;
      tb_q      <= `SNB_TB_RST;
      refused_q <= 1'b0;
    end
    else
    begin
      refused_q <= bp_wr & ~wp_n_q & lock_reg_write_disable;
      if (bp_wr && !(!wp_n_q && lock_reg_write_disable))
      begin
        bp_q <= bp_wr_data;
        tb_q <= tb_wr_data;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      col_ok_q <= 1'b1;
      plane_q  <= 1'b0;
    end
    else
    begin
      col_ok_q <= (col_addr <= `SNB_COL_LAST);
      plane_q  <= row_addr[`SNB_PLANE_BIT];
    end
  end

  assign io_out             = io_out_q;
  assign io_oe_n            = oe_n_q;
  assign rx_overrun         = overrun_q;
  assign selected           = sel;
  assign held               = (hs_q == HS_HELD) || (hs_q == HS_EXIT);
  assign mode3              = mode3_q;
  assign block_protect_bits = bp_q;
  assign top_bottom_select  = tb_q;
  assign bp_wr_refused      = refused_q;
  assign wp_n_level         = wp_n_q;
  assign col_in_bounds      = col_ok_q;
  assign plane_select       = plane_q;
endmodule

// file: core/snb_cfg.svh
// constants for the serial nand bus front end
`ifndef SNB_CFG_SVH
`define SNB_CFG_SVH
`define SNB_BYTE_W     8
`define SNB_LN_X1      2'h0
`define SNB_LN_X2      2'h1
`define SNB_LN_X4      2'h2
`define SNB_COL_LAST   12'h87F
`define SNB_PLANE_BIT  6
`define SNB_ROW_W      17
`define SNB_BP_RST     4'h0
`define SNB_TB_RST     1'b0
`define SNB_SYNC_RST   6'h3E
`define SNB_TX_FILL    8'hFF
`endif

// file: core/snb_pkg.sv
// types shared by the serial nand bus front end
`include "snb_cfg.svh"
package snb_pkg;
  typedef enum logic [1:0] {HS_RUN, HS_ENTER, HS_HELD, HS_EXIT} snb_hold_e;
  typedef struct packed
  {
    logic                   first;
    logic [`SNB_BYTE_W-1:0] data;
  } snb_word_s;
endpackage

// file: core/snb_stream_if.sv
// valid/ready word carrier between the front end and its buffer
interface snb_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: core/snb_fifo2.sv
// small ring buffer with valid/ready on both sides
module snb_fifo2
  import snb_pkg::*;
#(
  parameter int W     = 9,
  parameter int DEPTH = 2
)
(
  input wire logic mclk,
  input wire logic srst,
  snb_stream_if.snk wr,
  snb_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wp_q] <= wr.data;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= bump(wp_q);
      if (pop)
        rp_q <= bump(rp_q);
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule

// file: verification/snb_bus_front_assertions.sv
// port-level checker for the serial nand bus front end
`include "snb_cfg.svh"
module snb_bus_front_chk (
  input wire logic [3:0] io_oe_n,
  input wire logic mclk,
  input wire logic srst,
  input wire logic hold_en,
  input wire logic [1:0] tx_lanes,
  input wire logic tx_active,
  input wire logic tx_ready,
  input wire logic selected,
  input wire logic held,
  input wire logic lock_reg_write_disable,
  input wire logic bp_wr,
  input wire logic [3:0] bp_wr_data,
  input wire logic tb_wr_data,
  input wire logic [3:0] block_protect_bits,
  input wire logic top_bottom_select,
  input wire logic bp_wr_refused,
  input wire logic wp_n_level,
  input wire logic [11:0] col_addr,
  input wire logic [`SNB_ROW_W-1:0] row_addr,
  input wire logic col_in_bounds,
  input wire logic plane_select,
  input wire logic rx_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // three cycles cover the enable register lag after deselect
  a_desel_float: assert property (!selected [*3] |-> io_oe_n == 4'hF)
    else $error("lines driven while deselected");
  a_held_so_off: assert property (held [*3] |-> io_oe_n[1])
    else $error("serial output driven while paused");
  a_hold_ignored: assert property (!hold_en [*3] |-> !held)
    else $error("pause taken with pause function off");
  a_prot_refuse: assert property (bp_wr && !wp_n_level && lock_reg_write_disable
    |=> bp_wr_refused && $stable(block_protect_bits)
    && $stable(top_bottom_select))
    else $error("protect bits changed while locked");
  a_prot_write: assert property (bp_wr && (wp_n_level || !lock_reg_write_disable)
    |=> !bp_wr_refused && block_protect_bits == $past(bp_wr_data)
    && top_bottom_select == $past(tb_wr_data))
    else $error("protect write lost");
  a_col_bound: assert property (!$past(srst) |->
    col_in_bounds == ($past(col_addr) <= `SNB_COL_LAST))
    else $error("column bound flag wrong");
  a_plane_sel: assert property (!$past(srst) |->
    plane_select == $past(row_addr[`SNB_PLANE_BIT]))
    else $error("plane select wrong");
  a_x1_lanes: assert property ((tx_lanes == `SNB_LN_X1) [*3]
    |-> io_oe_n[3] && io_oe_n[2] && io_oe_n[0])
    else $error("extra lanes driven in single-line mode");
  a_tx_pulse: assert property (tx_ready |-> tx_active ##1 !tx_ready)
    else $error("byte load outside output phase");
  c_held: cover property (held);
  c_refused: cover property (bp_wr_refused);
  c_tx: cover property (tx_ready);
  c_rx: cover property (rx_valid);
endmodule
bind snb_bus_front snb_bus_front_chk u_chk (.*);

// file: verification/snb_host_model.sv
// behavioural host controller driving the serial bus pins
module snb_host_model (
  input wire logic mclk,
  input wire logic [3:0] pin,
  output logic sck,
  output logic cs_n,
  output logic [3:0] h_out,
  output logic [3:0] h_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle, wp_v, hold_v, q4;
  logic [3:0] hd;
  // control lines follow wp_v/hold_v at once, even between frames
  assign h_out = q4 ? hd : {hold_v, wp_v, hd[1:0]};
  initial
  begin
    {sck, idle, q4, hd} = 7'h00;
    {cs_n, wp_v, hold_v} = 3'h7;
    h_en = 4'hC;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic sel(input logic m3);
    @(posedge mclk);
    idle = m3;
    sck <= m3;
    wt(8);
    cs_n <= 1'b0;
    wt(8);
  endtask
  task automatic desel();
    @(posedge mclk);
    sck <= idle;
    wt(8);
    cs_n <= 1'b1;
    q4 <= 1'b0;
    h_en <= 4'hC;
    wt(8);
  endtask
  task automatic pause_step(input logic s, input logic h);
    @(posedge mclk);
    sck <= s;
    wt(8);
    hold_v <= h;
    wt(8);
  endtask
  task automatic xfer(input logic rd, input logic [1:0] ln,
                      input logic [7:0] d, output logic [7:0] q);
    int k;
    logic [7:0] s;
    logic x4;
    logic x1;
    x4 = (ln == 2'h2);
    x1 = (ln == 2'h0);
    k = x1 ? 1 : x4 ? 4 : 2;
    s = d;
    q = 8'h00;
    q4 <= x4;
    h_en <= {~(rd & x4), ~(rd & x4), ~rd & ~x1, ~rd | x1};
    for (int i = 0; i < 8 / k; i++)
    begin
      @(posedge mclk);
      sck <= 1'b0;
      hd <= s[7:4] >> (4 - k);
      s = s << k;
      wt(8);
      sck <= 1'b1;
      q = (q << k) | (x1 ? {3'h0, pin[1]} : x4 ? pin : {2'h0, pin[1:0]});
      wt(7);
    end
  endtask
endmodule

// file: verification/snb_bus_front_tb_top.sv
// self-checking bench for the serial nand bus front end
module snb_bus_front_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, srst = 1, sck, cs_n, flt = 0, hold_en = 0, tx_active = 0;
  logic tx_valid = 0, rx_ready = 1, lock_reg_write_disable = 0, bp_wr = 0;
  logic [1:0] rx_lanes = 0, tx_lanes = 0;
  logic [3:0] io_in, io_out, io_oe_n, h_out, h_en, bp_wr_data = 0;
  logic [3:0] block_protect_bits;
  logic [7:0] tx_data, rx_data, tx_mem[4], d, q;
  logic [11:0] col_addr = 0;
  logic [16:0] row_addr = 0;
  logic tb_wr_data = 0, tx_ready, rx_first, rx_valid, rx_overrun, selected;
  logic held, mode3, top_bottom_select, bp_wr_refused, wp_n_level, ref_seen;
  logic col_in_bounds, plane_select;
  logic [8:0] got_q[$], exp_q[$];
  logic [4:0] exp_bp;
  int tx_idx, err_count, total_checks;
  initial
    forever #2.5 mclk = ~mclk;
  // undriven data lines wander; wp and hold lines have pull-ups
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & h_en & h_out)
               | (io_oe_n & ~h_en & {2'h3, flt, ~flt});
  assign tx_data = tx_mem[tx_idx[1:0]];
  snb_bus_front u_snb_bus_front (.*);
  snb_host_model u_snb_host_model (.mclk(mclk), .pin(io_in), .sck(sck),
    .cs_n(cs_n), .h_out(h_out), .h_en(h_en));
  always @(posedge mclk)
  begin
    flt <= ~flt;
    if (tx_ready === 1'b1)
      tx_idx <= tx_idx + 1;
    if (bp_wr_refused === 1'b1)
      ref_seen <= 1'b1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      got_q.push_back({rx_first, rx_data});
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic drain(input string s);
    int i;
    for (i = 0; i < 200; i++)
    begin
      if (got_q.size() >= exp_q.size())
        break;
      @(posedge mclk);
    end
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[j])
      if (j < got_q.size())
        chk(16'(got_q[j]), 16'(exp_q[j]));
    got_q.delete();
    exp_q.delete();
    $display("test %s done", s);
    if (i == 200)
    begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic rx_frame(input logic m3, input logic [1:0] ln, input int n,
                          input logic keep);
    rx_lanes <= ln;
    u_snb_host_model.sel(m3);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom());
      u_snb_host_model.xfer(1'b0, ln, d, q);
      exp_q.push_back({i == 0, d});
    end
    chk(mode3, m3);
    if (!keep)
      u_snb_host_model.desel();
  endtask
  initial
  begin
    void'($urandom(32'hA94DB0BF));
    wt(5);
    srst <= 1'b0;
    wt(4);
    chk({io_oe_n, selected, held, col_in_bounds, block_protect_bits},
        {4'hF, 1'b0, 1'b0, 1'b1, 4'h0});
    for (int ln = 0; ln < 3; ln++)
    begin
      rx_frame(ln[0], 2'(ln), 3, 1'b0);
      drain("rx");
      foreach (tx_mem[i])
        tx_mem[i] = 8'($urandom());
      tx_idx <= 0;
      tx_valid <= 1'b1;
      // command byte first, so mode 0 also has a fall before output
      rx_frame(~ln[0], 2'h0, 1, 1'b1);
      tx_active <= 1'b1;
      tx_lanes <= 2'(ln);
      for (int i = 0; i < 4; i++)
      begin
        if (i == 3)
          tx_valid <= 1'b0;
        u_snb_host_model.xfer(1'b1, 2'(ln), 8'h00, q);
        chk(q, i == 3 ? 8'hFF : tx_mem[i]);
      end
      tx_active <= 1'b0;
      tx_lanes <= 2'h0;
      u_snb_host_model.desel();
      drain("tx");
    end
    rx_ready <= 1'b0;
    rx_frame(1'b0, 2'h0, 3, 1'b0);
    chk(rx_overrun, 1'b1);
    void'(exp_q.pop_back());
    rx_ready <= 1'b1;
    drain("overrun");
    rx_frame(1'b0, 2'h0, 1, 1'b0);
    // mode 3: clock already high, so no live rise before the pause
    u_snb_host_model.sel(1'b1);
    u_snb_host_model.pause_step(1'b1, 1'b0);
    chk(held, 1'b0);
    u_snb_host_model.pause_step(1'b1, 1'b1);
    hold_en <= 1'b1;
    u_snb_host_model.pause_step(1'b1, 1'b0);
    chk(held, 1'b0);
    u_snb_host_model.pause_step(1'b0, 1'b0);
    chk(held, 1'b1);
    u_snb_host_model.pause_step(1'b1, 1'b0);
    u_snb_host_model.pause_step(1'b1, 1'b1);
    chk(held, 1'b1);
    u_snb_host_model.pause_step(1'b0, 1'b1);
    chk(held, 1'b0);
    d = 8'($urandom());
    u_snb_host_model.xfer(1'b0, 2'h0, d, q);
    exp_q.push_back({1'b1, d});
    u_snb_host_model.desel();
    drain("hold");
    exp_bp = 5'h00;
    for (int i = 0; i < 4; i++)
    begin
      u_snb_host_model.wp_v <= i[0];
      lock_reg_write_disable <= i[1];
      ref_seen <= 1'b0;
      d = 8'($urandom());
      {tb_wr_data, bp_wr_data} <= d[4:0];
      wt(8);
      bp_wr <= 1'b1;
      wt(1);
      bp_wr <= 1'b0;
      wt(3);
      if (i != 2)
        exp_bp = d[4:0];
      chk({ref_seen, top_bottom_select, block_protect_bits},
          {i == 2, exp_bp});
    end
    $display("test protect done");
    for (int i = 0; i < 5; i++)
    begin
      // both sides of the last valid column, the top, zero, then random
      col_addr <= i == 0 ? 12'h87F : i == 1 ? 12'h880 :
                  i == 2 ? 12'hFFF : i == 3 ? 12'h000 : 12'($urandom());
      row_addr <= 17'($urandom());
      wt(3);
      chk(col_in_bounds, col_addr <= 12'h87F);
      chk(plane_select, row_addr[6]);
    end
    $display("test address done");
    end_of_test();
  end
endmodule
